//--- inc/lpc_map.svh
`ifndef LPC_MAP_SVH
`define LPC_MAP_SVH

// clock rate in kHz, so one millisecond is this many cycles
`define LPC_CLK_KHZ        125000

// times in milliseconds
`define LPC_DEBOUNCE_MS    20
`define LPC_ONE_SEC_MS     1000
`define LPC_BLINK_HALF_MS  250
`define LPC_EVENT_MS       100
`define LPC_ENC_HOLD_MS    50

// error blink codes, value is the number of lit LEDs per strip
`define LPC_ERR_NONE       4'h0
`define LPC_ERR_CARD_ABSENT 4'h1
`define LPC_ERR_NOT_MOUNTED 4'h2
`define LPC_ERR_WRITE_PROT 4'h3
`define LPC_ERR_FILE_SYS   4'h4
`define LPC_ERR_FLASH_WR   4'h5
`define LPC_ERR_OVR_PACER  4'h6
`define LPC_ERR_OVR_FIFO   4'h7
`define LPC_ERR_OVR_EVENT  4'h8
`define LPC_ERR_DMA        4'h9
`define LPC_ERR_CARD_FULL  4'hA
`define LPC_ERR_FILE_MAX   4'hB
`define LPC_ERR_LOG_CFG    4'hC
`define LPC_ERR_CFG_DEVICE 4'hD

// terminal strips
`define LPC_STRIP_NUM      2
`define LPC_STRIP_LEDS     16
`define LPC_STRIP_CHANS    8

`endif

//--- inc/lpc_pkg.sv
package lpc_pkg;

  typedef enum logic [1:0] {
    LPC_IND_ALL,
    LPC_IND_TOP,
    LPC_IND_NONE
  } lpc_ind_e;

  typedef struct packed {
    logic start;
    logic force_fire;
    logic save;
    logic load;
    logic indicator_cycle;
  } lpc_btn_s;

  typedef struct packed {
    logic log_start;
    logic log_stop;
    logic force_trigger;
    logic event_mark;
    logic cfg_save;
    logic cfg_load;
  } lpc_cmd_s;

  typedef struct packed {
    logic card_activity_led;
    logic card_status_led;
    logic logging_led;
    logic acquisition_fired_led;
    logic event_led;
  } lpc_top_led_s;

endpackage : lpc_pkg

//--- hw/lpc_panel.sv
`timescale 1ns/1ns
`include "lpc_map.svh"

// What this block does
// [RULE1] while USB is connected, ignore top buttons and darken top LEDs
// [RULE2] blink card activity LED while a card read or write runs
// [RULE3] card operation without card lights card status LED one second
// [RULE4] blink card status LED on card fault or invalid configuration
// [RULE5] errors one to five blink that many analog LEDs per strip
// [RULE6] errors six to thirteen blink that many analog LEDs per strip
// [RULE7] any top button press acknowledges and stops the error blinking
// [RULE8] logging LED steady on while logging, off while idle
// [RULE9] acquisition fired LED on once the acquisition has triggered
// [RULE10] event LED blinks once for each event
// [RULE11] all LEDs on at reset; cycle button steps top only, none, all
// [RULE12] force fire press triggers when waiting, marks event when recording
// [RULE13] start press begins logging with valid card, no USB; stops if logging
// [RULE14] save press writes current logging configuration to the card
// [RULE15] load press reads and applies latest configuration from the card
// [RULE16] digital input LED lit while voltage is on that input
// [RULE17] output state LED follows the alarm relay state
// [RULE18] analog channel LED lit while channel is in the scan list
// [RULE19] counter LED lit while that encoder value is changing
// [RULE20] relay energized when enabled, triggered and recording
// [RULE21] power LED when ready, USB LED when on an active port
// [RULE22] buttons debounced; one action per press on the press edge
// [RULE23] error code held until acknowledged; newer error replaces it
module lpc_panel
  import lpc_pkg::*;
#(
  parameter int MS_CYCLES = `LPC_CLK_KHZ,
  parameter int DEB_MS    = `LPC_DEBOUNCE_MS,
  parameter int SEC_MS    = `LPC_ONE_SEC_MS,
  parameter int BLINK_MS  = `LPC_BLINK_HALF_MS,
  parameter int EVENT_MS  = `LPC_EVENT_MS,
  parameter int ENC_MS    = `LPC_ENC_HOLD_MS,
  parameter int NDIN      = 16,
  parameter int NCH       = 16,
  parameter int NCNT      = 4
) (
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire lpc_btn_s              btn,
  input  wire logic                  usb_connected,
  input  wire logic                  usb_active,
  input  wire logic                  powered_ready,
  input  wire logic                  card_busy,
  input  wire logic                  card_present,
  input  wire logic                  card_fault,
  input  wire logic                  cfg_valid,
  input  wire logic                  op_attempt,
  input  wire logic                  err_valid,
  input  wire logic [3:0]            err_code,
  input  wire logic                  logging_active,
  input  wire logic                  waiting_trigger,
  input  wire logic                  events_recording,
  input  wire logic                  acq_triggered,
  input  wire logic                  event_pulse,
  input  wire logic [NDIN-1:0]       din,
  input  wire logic                  relay_energized,
  input  wire logic                  relay_alarm_en,
  input  wire logic                  acquisition_fired_led_met,
  input  wire logic                  recording,
  input  wire logic [NCH-1:0]        scan_list,
  input  wire logic [NCNT-1:0]       enc_change,
  output lpc_top_led_s               top_led,
  output logic                       power_led,
  output logic                       usb_activity_led,
  output logic [NDIN-1:0]            din_led,
  output logic                       relay_state_led,
  output logic [`LPC_STRIP_NUM*`LPC_STRIP_LEDS-1:0] analog_led,
  output logic [NCNT-1:0]            counter_led,
  output logic                       relay_drive,
  output lpc_cmd_s                   cmd
);

  localparam int MS_W = $clog2(MS_CYCLES + 1);
  localparam int DB_W = $clog2(DEB_MS + 1);
  localparam int TM_W = $clog2(SEC_MS + BLINK_MS + EVENT_MS + ENC_MS + 1);
  localparam int NLED = `LPC_STRIP_NUM * `LPC_STRIP_LEDS;

  // millisecond enable and blink phase
  logic [MS_W-1:0] ms_cnt_reg;
  logic            ms_tick_reg;
  logic [TM_W-1:0] blink_cnt_reg;
  logic            blink_phase_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ms_cnt_reg  <= '0;
      ms_tick_reg <= 1'b0;
    end else if (ms_cnt_reg == MS_W'(MS_CYCLES - 1)) begin
      ms_cnt_reg  <= '0;
      ms_tick_reg <= 1'b1;
    end else begin
      ms_cnt_reg  <= ms_cnt_reg + 1'b1;
      ms_tick_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      blink_cnt_reg   <= '0;
      blink_phase_reg <= 1'b0;
    end else if (ms_tick_reg) begin
      if (blink_cnt_reg == TM_W'(BLINK_MS - 1)) begin
        blink_cnt_reg   <= '0;
        blink_phase_reg <= ~blink_phase_reg;
      end else begin
        blink_cnt_reg <= blink_cnt_reg + 1'b1;
      end
    end
  end

  // button debounce: a level must hold DEB_MS ticks to be taken
  logic [4:0] btn_raw;
  wire  logic [4:0] btn_db;
  logic [4:0] btn_prev_reg;
  logic [4:0] press;
  lpc_btn_s   act_s;
  logic       any_press;
  logic       ack;
  logic [3:0] err_code_reg;

  assign btn_raw = btn;

  for (genvar gi = 0; gi < 5; gi++) begin : g_deb
    logic [DB_W-1:0] cnt_reg;
    logic            db_reg;
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        cnt_reg <= '0;
        db_reg  <= 1'b0;
      end else if (ms_tick_reg) begin
        if (btn_raw[gi] == db_reg) begin
          cnt_reg <= '0;
        end else if (cnt_reg == DB_W'(DEB_MS - 1)) begin
          cnt_reg <= '0;
          db_reg  <= btn_raw[gi]; // RULE22
        end else begin
          cnt_reg <= cnt_reg + 1'b1;
        end
      end
    end
    assign btn_db[gi] = db_reg;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      btn_prev_reg <= '0;
    end else begin
      btn_prev_reg <= btn_db;
    end
  end

  // press edge, dropped while USB holds the panel
  assign press     = btn_db & ~btn_prev_reg & {5{~usb_connected}}; // RULE22 RULE1
  assign any_press = |press;
  assign ack       = any_press && (err_code_reg != `LPC_ERR_NONE); // RULE7
  // a press that acknowledges an error does nothing else
  assign act_s     = lpc_btn_s'(press & {5{~ack}});

  // button commands
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd <= '0;
    end else begin
      cmd.log_start     <= act_s.start && !logging_active &&
                           card_present && cfg_valid; // RULE13
      cmd.log_stop      <= act_s.start && logging_active; // RULE13
      cmd.force_trigger <= act_s.force_fire && logging_active &&
                           waiting_trigger; // RULE12
      cmd.event_mark    <= act_s.force_fire && events_recording; // RULE12
      cmd.cfg_save      <= act_s.save; // RULE14
      cmd.cfg_load      <= act_s.load; // RULE15
    end
  end

  // indicator group
  lpc_ind_e ind_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ind_reg <= LPC_IND_ALL; // RULE11
    end else if (act_s.indicator_cycle) begin
      case (ind_reg)
        LPC_IND_ALL:  ind_reg <= LPC_IND_TOP; // RULE11
        LPC_IND_TOP:  ind_reg <= LPC_IND_NONE;
        LPC_IND_NONE: ind_reg <= LPC_IND_ALL;
        default:      ind_reg <= LPC_IND_ALL;
      endcase
    end
  end

  // error code, a new report wins over an acknowledge
  logic       err_take;
  assign err_take = err_valid && (err_code != `LPC_ERR_NONE) &&
                    (err_code <= `LPC_ERR_CFG_DEVICE);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      err_code_reg <= `LPC_ERR_NONE;
    end else if (err_take) begin
      err_code_reg <= err_code; // RULE23 RULE5 RULE6
    end else if (ack) begin
      err_code_reg <= `LPC_ERR_NONE; // RULE7
    end
  end

  // one second steady lamp for an attempt without a card
  logic [TM_W-1:0] steady_ms_reg;
  logic            nocard;
  assign nocard = (op_attempt || act_s.start && !logging_active) &&
                  !card_present;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      steady_ms_reg <= '0;
    end else if (nocard) begin
      steady_ms_reg <= TM_W'(SEC_MS); // RULE3
    end else if (ms_tick_reg && steady_ms_reg != '0) begin
      steady_ms_reg <= steady_ms_reg - 1'b1;
    end
  end

  // event lamp stretch
  logic [TM_W-1:0] event_ms_reg;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      event_ms_reg <= '0;
    end else if (event_pulse) begin
      event_ms_reg <= TM_W'(EVENT_MS); // RULE10
    end else if (ms_tick_reg && event_ms_reg != '0) begin
      event_ms_reg <= event_ms_reg - 1'b1;
    end
  end

  // encoder activity stretch per counter channel
  wire logic [NCNT-1:0] enc_busy;

  for (genvar gc = 0; gc < NCNT; gc++) begin : g_enc
    logic [TM_W-1:0] hold_reg;
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        hold_reg <= '0;
      end else if (enc_change[gc]) begin
        hold_reg <= TM_W'(ENC_MS); // RULE19
      end else if (ms_tick_reg && hold_reg != '0) begin
        hold_reg <= hold_reg - 1'b1;
      end
    end
    assign enc_busy[gc] = (hold_reg != '0);
  end

  // analog strip pattern: blink code, otherwise the scan list
  wire logic [NLED-1:0] analog_next;

  for (genvar gs = 0; gs < `LPC_STRIP_NUM; gs++) begin : g_strip
    for (genvar gp = 0; gp < `LPC_STRIP_LEDS; gp++) begin : g_pos
      localparam logic [4:0] PI = 5'(gp);
      localparam int CH = (gp < 4) ? gs * 4 + gp : 8 + gs * 4 + gp - 4;
      logic scan_bit;
      if (gp < `LPC_STRIP_CHANS && CH < NCH) begin : g_ch
        assign scan_bit = scan_list[CH]; // RULE18
      end else begin : g_nch
        assign scan_bit = 1'b0;
      end
      assign analog_next[gs * `LPC_STRIP_LEDS + gp] =
        (err_code_reg != `LPC_ERR_NONE) ?
        (({1'b0, err_code_reg} > PI) && blink_phase_reg) : // RULE5 RULE6
        scan_bit;
    end
  end

  // lamp drive
  logic top_en;
  logic term_en;
  logic status_err;

  assign top_en     = !usb_connected && (ind_reg != LPC_IND_NONE); // RULE1
  assign term_en    = (ind_reg == LPC_IND_ALL); // RULE11
  assign status_err = card_fault || (card_present && !cfg_valid);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      top_led <= '0;
    end else begin
      top_led.card_activity_led     <= top_en && card_busy &&
                                       blink_phase_reg; // RULE2
      top_led.card_status_led       <= top_en && (steady_ms_reg != '0 ||
                                       status_err && blink_phase_reg); // RULE3 RULE4
      top_led.logging_led           <= top_en && logging_active; // RULE8
      top_led.acquisition_fired_led <= top_en && acq_triggered; // RULE9
      top_led.event_led             <= top_en && event_ms_reg != '0; // RULE10
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      din_led         <= '0;
      relay_state_led <= 1'b0;
      analog_led      <= '0;
      counter_led     <= '0;
    end else begin
      din_led         <= term_en ? din : '0; // RULE16
      relay_state_led <= term_en && relay_energized; // RULE17
      analog_led      <= term_en ? analog_next : '0; // RULE18
      counter_led     <= term_en ? enc_busy : '0; // RULE19
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      power_led        <= 1'b0;
      usb_activity_led <= 1'b0;
      relay_drive      <= 1'b0;
    end else begin
      power_led        <= powered_ready; // RULE21
      usb_activity_led <= usb_active; // RULE21
      relay_drive      <= relay_alarm_en && acquisition_fired_led_met && recording; // RULE20
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  a_usb_no_cmd: assert property ( // RULE1
    usb_connected |=> cmd == '0
  ) else $error("command issued while usb connected");
  a_usb_top_dark: assert property ( // RULE1
    usb_connected |=> top_led == '0
  ) else $error("top led lit while usb connected");
  a_start_gate: assert property ( // RULE13
    cmd.log_start |-> $past(card_present && cfg_valid && !usb_connected)
  ) else $error("logging started without card, config or with usb");
  a_stop_press: assert property ( // RULE13
    act_s.start && logging_active |=> cmd.log_stop && !cmd.log_start
  ) else $error("start press while logging did not stop");
  a_fire_event: assert property ( // RULE12
    act_s.force_fire && events_recording && !logging_active
    |=> cmd.event_mark && !cmd.force_trigger
  ) else $error("force fire press handled wrongly");
  a_err_replace: assert property ( // RULE23
    err_take |=> err_code_reg == $past(err_code) [*1] ##1
    (err_code_reg == $past(err_code, 2) || $past(err_take) || $past(ack))
  ) else $error("error code not held or replaced");
  a_err_ack: assert property ( // RULE7
    ack && !err_take |=> err_code_reg == `LPC_ERR_NONE
  ) else $error("acknowledge did not clear error code");
  a_nocard_hold: assert property ( // RULE3
    nocard && !usb_connected && ind_reg == LPC_IND_ALL
    ##1 !usb_connected [*2]
    |-> ##1 top_led.card_status_led
  ) else $error("card status lamp not lit after attempt without card");
  a_ind_step: assert property ( // RULE11
    act_s.indicator_cycle && ind_reg == LPC_IND_TOP
    |=> ind_reg == LPC_IND_NONE ##1 term_en == 1'b0
  ) else $error("indicator cycle did not step");
  a_relay_drive: assert property ( // RULE20
    relay_alarm_en && acquisition_fired_led_met && recording |=> relay_drive
  ) else $error("relay not energized when armed and recording");
  a_log_led: assert property ( // RULE8
    !logging_active && $past(!logging_active) |=> !top_led.logging_led
  ) else $error("logging lamp lit while idle");
  a_cmd_single: assert property ( // RULE22
    cmd.cfg_save |=> !cmd.cfg_save [*2]
  ) else $error("one save press gave repeated command");

endmodule : lpc_panel

//--- verification/lpc_btn_model.sv
`timescale 1ns/1ns
// operator at the panel: every change of a button chatters before it settles
module lpc_btn_model
  import lpc_pkg::*;
(
  input  wire lpc_btn_s want,
  input  wire logic     clk,
  output lpc_btn_s      btn
);
  lpc_btn_s prev = '0;
  lpc_btn_s goal = '0;
  int       bnc  = 0;
  initial btn = '0;
  always @(negedge clk) begin
    if (want !== goal) begin
      prev = goal;
      goal = want;
      bnc  = 4;
    end
    if (bnc > 0) bnc--;
    btn <= (bnc % 2 == 1) ? prev : goal;
  end
endmodule : lpc_btn_model

//--- verification/testbench.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
  num_errors++; $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end
module testbench;
  import lpc_pkg::*;
  logic clk, reset_n, usb_connected, usb_active, powered_ready, card_busy;
  logic card_present, card_fault, cfg_valid, op_attempt, err_valid;
  logic logging_active, waiting_trigger, events_recording, acq_triggered;
  logic event_pulse, relay_energized, relay_alarm_en, acquisition_fired_led_met, recording;
  logic power_led, usb_activity_led, relay_state_led, relay_drive;
  logic [3:0]   err_code, enc_change, counter_led;
  logic [15:0]  din, scan_list, din_led;
  logic [31:0]  analog_led;
  lpc_btn_s     want, btn;
  lpc_top_led_s top_led;
  lpc_cmd_s     cmd, seen, e;
  int           num_errors = 0;
  int           checks_done = 0;
  int           cycles = 0;
  int           n;

  lpc_btn_model i_btn (.want(want), .clk(clk), .btn(btn));
  lpc_panel #(.MS_CYCLES(4), .DEB_MS(2), .SEC_MS(5), .BLINK_MS(2),
    .EVENT_MS(3)) i_dut (
    .clk(clk), .reset_n(reset_n), .btn(btn), .usb_connected(usb_connected),
    .usb_active(usb_active), .powered_ready(powered_ready),
    .card_busy(card_busy), .card_present(card_present),
    .card_fault(card_fault), .cfg_valid(cfg_valid), .op_attempt(op_attempt),
    .err_valid(err_valid), .err_code(err_code),
    .logging_active(logging_active), .waiting_trigger(waiting_trigger),
    .events_recording(events_recording), .acq_triggered(acq_triggered),
    .event_pulse(event_pulse), .din(din), .relay_energized(relay_energized),
    .relay_alarm_en(relay_alarm_en), .acquisition_fired_led_met(acquisition_fired_led_met),
    .recording(recording), .scan_list(scan_list), .enc_change(enc_change),
    .top_led(top_led), .power_led(power_led),
    .usb_activity_led(usb_activity_led), .din_led(din_led),
    .relay_state_led(relay_state_led), .analog_led(analog_led),
    .counter_led(counter_led), .relay_drive(relay_drive), .cmd(cmd));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task tick(input int k);
    repeat (k) @(negedge clk);
  endtask : tick

  // holds a button 30 cycles, releases it 30, collects commands meanwhile
  task press(input lpc_btn_s b);
    seen = '0;
    n = 0;
    want = b;
    for (int i = 0; i < 60; i++) begin
      if (i == 30) want = '0;
      @(negedge clk);
      seen |= cmd;
      if (cmd !== '0) n++;
    end
  endtask : press

  task give_verdict;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict

  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      num_errors++;
      give_verdict;
    end
  end

  task t_top;
    logging_active = 1'b1;
    acq_triggered = 1'b1;
    tick(3);
    `CHK("log_led", 1'b1, top_led.logging_led)
    `CHK("fired_led", 1'b1, top_led.acquisition_fired_led)
    logging_active = 1'b0;
    acq_triggered = 1'b0;
    event_pulse = 1'b1;
    tick(1);
    event_pulse = 1'b0;
    tick(2);
    `CHK("log_off", 1'b0, top_led.logging_led)
    `CHK("event_on", 1'b1, top_led.event_led)
    tick(22);
    `CHK("event_off", 1'b0, top_led.event_led)
  endtask : t_top

  task t_cmds;
    waiting_trigger = 1'b1;
    events_recording = 1'b1;
    press('{force_fire: 1'b1, default: 1'b0});
    e = '0;
    e.event_mark = 1'b1;
    `CHK("fire_idle", e, seen)
    logging_active = 1'b1;
    press('{force_fire: 1'b1, default: 1'b0});
    e.force_trigger = 1'b1;
    `CHK("fire_cmd", e, seen)
    `CHK("fire_once", 1, n)
    logging_active = 1'b0;
    waiting_trigger = 1'b0;
    events_recording = 1'b0;
    press('{save: 1'b1, default: 1'b0});
    e = '0;
    e.cfg_save = 1'b1;
    `CHK("save_cmd", e, seen)
    press('{load: 1'b1, default: 1'b0});
    e = '0;
    e.cfg_load = 1'b1;
    `CHK("load_cmd", e, seen)
  endtask : t_cmds

  task t_start;
    press('{start: 1'b1, default: 1'b0});
    `CHK("start_ok", 1'b1, seen.log_start)
    `CHK("start_once", 1, n)
    logging_active = 1'b1;
    press('{start: 1'b1, default: 1'b0});
    `CHK("stop", 1'b1, seen.log_stop)
    `CHK("no_restart", 1'b0, seen.log_start)
    logging_active = 1'b0;
    cfg_valid = 1'b0;
    press('{start: 1'b1, default: 1'b0});
    `CHK("no_cfg", 1'b0, seen.log_start)
    cfg_valid = 1'b1;
    card_present = 1'b0;
    press('{start: 1'b1, default: 1'b0});
    `CHK("no_card", 1'b0, seen.log_start)
    op_attempt = 1'b1;
    tick(1);
    op_attempt = 1'b0;
    tick(3);
    `CHK("lamp_on", 1'b1, top_led.card_status_led)
    tick(11);
    `CHK("lamp_hold", 1'b1, top_led.card_status_led)
    tick(20);
    `CHK("lamp_off", 1'b0, top_led.card_status_led)
    card_present = 1'b1;
  endtask : t_start

  task t_usb;
    usb_connected = 1'b1;
    usb_active = 1'b1;
    logging_active = 1'b1;
    powered_ready = 1'b0;
    tick(3);
    `CHK("usb_dark", 5'h00, top_led)
    `CHK("usb_led", 1'b1, usb_activity_led)
    `CHK("power_off", 1'b0, power_led)
    powered_ready = 1'b1;
    logging_active = 1'b0;
    press('{start: 1'b1, default: 1'b0});
    `CHK("usb_ignore", 0, n)
    usb_connected = 1'b0;
    usb_active = 1'b0;
  endtask : t_usb

  task t_err;
    logic [31:0] ex, acc_or, acc_and;
    // an out-of-range code is ignored; each later code replaces the last
    for (int c = 14; c >= 1; c--) begin
      err_code = 4'(c);
      err_valid = 1'b1;
      tick(1);
      err_valid = 1'b0;
      tick(3);
      ex = (c > 13) ? 32'h0 : (32'h1 << c) - 32'h1;
      ex = {ex[15:0], ex[15:0]};
      acc_or = '0;
      acc_and = '1;
      repeat (24) begin
        @(negedge clk);
        acc_or |= analog_led;
        acc_and &= analog_led;
      end
      `CHK("err_mask", ex, acc_or)
      `CHK("err_blink", 32'h0, acc_and)
    end
    press('{save: 1'b1, default: 1'b0});
    `CHK("ack_only", 0, n)
    `CHK("ack_dark", 32'h0, analog_led)
  endtask : t_err

  task t_term;
    din = 16'hA5C3;
    relay_energized = 1'b1;
    scan_list = 16'h8111;
    relay_alarm_en = 1'b1;
    acquisition_fired_led_met = 1'b1;
    recording = 1'b1;
    enc_change = 4'h4;
    tick(1);
    enc_change = 4'h0;
    tick(2);
    `CHK("din_led", 16'hA5C3, din_led)
    `CHK("relay_led", 1'b1, relay_state_led)
    `CHK("scan_led", 32'h00810011, analog_led)
    `CHK("enc_led", 4'h4, counter_led)
    `CHK("relay_on", 1'b1, relay_drive)
    recording = 1'b0;
    relay_energized = 1'b0;
    tick(150);
    `CHK("enc_hold", 4'h4, counter_led)
    `CHK("relay_off", 1'b0, relay_drive)
    `CHK("relay_led0", 1'b0, relay_state_led)
    tick(60);
    `CHK("enc_off", 4'h0, counter_led)
    recording = 1'b1;
    relay_alarm_en = 1'b0;
    tick(2);
    `CHK("relay_unarmed", 1'b0, relay_drive)
  endtask : t_term

  task t_card;
    lpc_top_led_s o, a;
    for (int k = 0; k < 3; k++) begin
      card_busy = (k == 0);
      card_fault = (k == 1);
      cfg_valid = (k != 2);
      tick(3);
      o = '0;
      a = '1;
      repeat (24) begin
        @(negedge clk);
        o |= top_led;
        a &= top_led;
      end
      if (k == 0) begin
        `CHK("act_blink", 2'b10, {o.card_activity_led, a.card_activity_led})
      end else begin
        `CHK("stat_blink", 2'b10, {o.card_status_led, a.card_status_led})
      end
    end
    card_busy = 1'b0;
    card_fault = 1'b0;
    cfg_valid = 1'b1;
  endtask : t_card

  task t_ind;
    logging_active = 1'b1;
    din = 16'hFFFF;
    press('{indicator_cycle: 1'b1, default: 1'b0});
    `CHK("ind_top", 17'h10000, {top_led.logging_led, din_led})
    press('{indicator_cycle: 1'b1, default: 1'b0});
    `CHK("ind_none", 17'h00000, {top_led.logging_led, din_led})
    press('{indicator_cycle: 1'b1, default: 1'b0});
    `CHK("ind_all", 17'h1FFFF, {top_led.logging_led, din_led})
    press('{indicator_cycle: 1'b1, default: 1'b0});
    reset_n = 1'b0;
    tick(2);
    reset_n = 1'b1;
    tick(2);
    `CHK("ind_reset", 17'h1FFFF, {top_led.logging_led, din_led})
  endtask : t_ind

  initial begin
    reset_n = 1'b0;
    want = '0;
    {usb_connected, usb_active, card_busy, card_fault, op_attempt} = '0;
    {err_valid, logging_active, waiting_trigger, events_recording} = '0;
    {acq_triggered, event_pulse, relay_energized, relay_alarm_en} = '0;
    {acquisition_fired_led_met, recording, err_code, enc_change, din, scan_list} = '0;
    powered_ready = 1'b1;
    card_present = 1'b1;
    cfg_valid = 1'b1;
    tick(5);
    `CHK("rst_power", 1'b0, power_led)
    reset_n = 1'b1;
    tick(1);
    `CHK("rst_top", 5'h00, top_led)
    `CHK("power_led", 1'b1, power_led)
    t_top();
    t_cmds();
    t_start();
    t_usb();
    t_err();
    t_term();
    t_card();
    t_ind();
    give_verdict();
  end
endmodule : testbench
